// >>> rtl/mcs_pkg.sv
package mcs_pkg;
  // register offsets (byte addresses = 4 * index)
  localparam logic [2:0] IDX_SELECT = 3'h0;
  localparam logic [2:0] IDX_PRESCALE = 3'h1;
  localparam logic [2:0] IDX_MON_CTRL = 3'h2;
  localparam logic [2:0] IDX_IRQ_CTRL = 3'h3;
  localparam logic [2:0] IDX_IRQ_FLAGS = 3'h4;
  localparam logic [2:0] IDX_STATUS = 3'h5;
  // unlock guard register, placed after the documented map
  localparam logic [2:0] IDX_GUARD = 3'h6;
  localparam logic [7:0] GUARD_KEY = 8'hd8;
  localparam logic [2:0] GUARD_WINDOW = 3'h4;

  // field positions
  localparam int SEL_CLOCK_OUT_ENABLE_BIT = 7;
  localparam int SEL_SRC_LSB = 0;
  localparam int PRE_ON_BIT = 0;
  localparam int PRE_RATIO_LSB = 1;
  localparam int MON_ON_BIT = 0;
  localparam int MON_TEST_BIT = 1;
  localparam int MON_SRC_LSB = 2;
  localparam int IRQ_EN_BIT = 0;
  localparam int IRQ_KIND_BIT = 7;
  localparam int FLAG_FAIL_BIT = 0;
  localparam int STAT_PLL_BIT = 5;

  // reset values
  localparam logic [7:0] RST_REG = 8'h00;

  // main clock source codes
  localparam logic [3:0] SRC_INT_FAST = 4'h0;
  localparam logic [3:0] SRC_INT_SLOW = 4'h1;
  localparam logic [3:0] SRC_EXT_WATCH = 4'h2;
  localparam logic [3:0] SRC_EXT_FAST = 4'h3;
  localparam logic [3:0] SRC_STARTUP = SRC_INT_FAST;

  // monitor source codes
  localparam logic [1:0] MON_MAIN = 2'h0;
  localparam logic [1:0] MON_EXT_FAST = 2'h1;
  localparam logic [1:0] MON_EXT_WATCH = 2'h2;

  typedef enum logic [1:0] {
    BUS_IDLE,
    BUS_ACK
  } mcs_bus_state_t;

  typedef struct packed {
    logic cyc;
    logic stb;
    logic we;
    logic [4:0] adr;
    logic [3:0] sel;
    logic [31:0] dat;
  } mcs_wb_req_t;

  typedef struct packed {
    logic ack;
    logic [31:0] dat;
  } mcs_wb_rsp_t;

  typedef struct packed {
    logic intFast;
    logic intSlow;
    logic extWatch;
    logic extFast;
  } mcs_osc_t;
endpackage : mcs_pkg

// >>> rtl/mcs_prescaler.sv
`timescale 1ns/1ns
// divides ref_clk by a ratio code; emits a one-cycle tick per period
module mcs_prescaler
  import mcs_pkg::*;
(
  // clock and reset
  input wire logic ref_clk,
  input wire logic nrst,
  // control
  input wire logic enable,
  input wire logic [3:0] ratio,
  // result
  output logic tick
);
  typedef struct packed {
    logic [6:0] count;
    logic tick;
  } mcs_pre_state_t;

  mcs_pre_state_t st;
  mcs_pre_state_t next_st;

  function automatic logic [6:0] ratio_div(input logic [3:0] code);
    case (code)
      4'h0: ratio_div = 7'h02;
      4'h1: ratio_div = 7'h04;
      4'h2: ratio_div = 7'h08;
      4'h3: ratio_div = 7'h10;
      4'h4: ratio_div = 7'h20;
      4'h5: ratio_div = 7'h40;
      4'h8: ratio_div = 7'h06;
      4'h9: ratio_div = 7'h0a;
      4'ha: ratio_div = 7'h0c;
      4'hb: ratio_div = 7'h18;
      4'hc: ratio_div = 7'h30;
      // reserved codes: fall back to the smallest ratio
      default: ratio_div = 7'h02;
    endcase
  endfunction : ratio_div

  always_comb begin
    next_st = st;
    if (!enable) begin
      next_st.count = 7'h00;
      next_st.tick = 1'b1;
    end else if (st.count >= ratio_div(ratio) - 7'h01) begin
      next_st.count = 7'h00;
      next_st.tick = 1'b1;
    end else begin
      next_st.count = st.count + 7'h01;
      next_st.tick = 1'b0;
    end
  end

  always_ff @(posedge ref_clk or negedge nrst) begin
    if (!nrst) begin
      st <= '0;
    end else begin
      st <= next_st;
    end
  end

  assign tick = st.tick;
endmodule : mcs_prescaler

// >>> rtl/mcs_main_clock_ctrl.sv
// The Wishbone slave port is this design's own decision.
`timescale 1ns/1ns
// Notes on behaviour
// - clock-out pin carries main clock while enable bit 7 is one.
// - clock-out enable clears on write of zero or main-clock failure.
// - select field 3:0 picks main source among four oscillators.
// - ratio field 4:1 maps codes to divide ratios 2..64, 6..48.
// - prescale on bit 0 zero passes clock undivided, one divides.
// - monitor source field 3:2 picks main, fast or watch oscillator.
// - all three monitor bits one locks them until reset.
// - test bit write one forces failure, write zero ends it.
// - monitoring runs only while monitor enable bit is one.
// - irq kind bit seven selects regular or non-maskable request.
// - failure request only while interrupt enable bit is one.
// - failure flag sets on any failure, forced ones included.
// - writing one clears failure flag, zero leaves it.
// - status bit 5 mirrors pll running.
// - forced main-clock failure switches main source to start-up.
module mcs_main_clock_ctrl
  import mcs_pkg::*;
(
  // clock and reset
  input wire logic ref_clk,
  input wire logic nrst,
  // wishbone slave
  input wire mcs_wb_req_t wbReq,
  output mcs_wb_rsp_t wbRsp,
  // oscillators and status
  input wire mcs_osc_t oscClk,
  input wire mcs_osc_t oscLost,
  input wire logic pllRunning,
  // clock outputs
  output logic mainClock,
  output logic clockOut,
  output logic clockOutEn,
  output logic [3:0] mainSource,
  output logic prescaleTick,
  // failure requests
  output logic failIrq,
  output logic failNmi
);
  typedef struct packed {
    mcs_bus_state_t bus;
    logic ack;
    logic [31:0] rdat;
    logic [2:0] guard;
    logic clkOutOn;
    logic [3:0] srcSel;
    logic [3:0] ratio;
    logic preOn;
    logic [1:0] monSrc;
    logic monTest;
    logic monOn;
    logic irqKind;
    logic irqEn;
    logic failFlag;
    logic mainClk;
    logic clock_out_enable;
    logic clkOutEn;
    logic irq;
    logic nmi;
  } mcs_state_t;

  mcs_state_t st;
  mcs_state_t next_st;
  logic tick;
  logic access;
  logic wrLane;
  logic [2:0] idx;
  logic locked;
  logic unlocked;
  logic failure;
  logic [7:0] wbyte;

  function automatic logic pick_src(input logic [3:0] code,
                                    input mcs_osc_t o);
    case (code)
      SRC_INT_FAST: pick_src = o.intFast;
      SRC_INT_SLOW: pick_src = o.intSlow;
      SRC_EXT_WATCH: pick_src = o.extWatch;
      SRC_EXT_FAST: pick_src = o.extFast;
      default: pick_src = o.intFast;
    endcase
  endfunction : pick_src

  function automatic logic watched_lost(input logic [1:0] code,
                                        input logic [3:0] main,
                                        input mcs_osc_t l);
    case (code)
      MON_MAIN: watched_lost = (main == SRC_INT_FAST) ? l.intFast :
                               (main == SRC_INT_SLOW) ? l.intSlow :
                               (main == SRC_EXT_WATCH) ? l.extWatch :
                               l.extFast;
      MON_EXT_FAST: watched_lost = l.extFast;
      MON_EXT_WATCH: watched_lost = l.extWatch;
      default: watched_lost = 1'b0;
    endcase
  endfunction : watched_lost

  mcs_prescaler u_prescaler (
    .ref_clk(ref_clk),
    .nrst(nrst),
    .enable(st.preOn),
    .ratio(st.ratio),
    .tick(tick)
  );

  assign access = wbReq.cyc && wbReq.stb && (st.bus == BUS_IDLE);
  assign idx = wbReq.adr[4:2];
  assign wrLane = access && wbReq.we && wbReq.sel[0];
  assign wbyte = wbReq.dat[7:0];
  assign unlocked = (st.guard != 3'h0);
  assign locked = st.monOn && st.irqEn && st.irqKind;
  // monitor idle while disabled; test bit forces a failure
  assign failure = st.monOn &&
                   (st.monTest || watched_lost(st.monSrc, st.srcSel,
                                               oscLost));

  always_comb begin
    next_st = st;
    next_st.ack = 1'b0;
    next_st.bus = BUS_IDLE;
    // guard window counts down once per bus access
    if (access && st.guard != 3'h0) begin
      next_st.guard = st.guard - 3'h1;
    end
    if (access) begin
      next_st.ack = 1'b1;
      next_st.bus = BUS_ACK;
      next_st.rdat = '0;
      case (idx)
        IDX_SELECT: begin
          next_st.rdat[SEL_CLOCK_OUT_ENABLE_BIT] = st.clkOutOn;
          next_st.rdat[SEL_SRC_LSB +: 4] = st.srcSel;
        end
        IDX_PRESCALE: begin
          next_st.rdat[PRE_ON_BIT] = st.preOn;
          next_st.rdat[PRE_RATIO_LSB +: 4] = st.ratio;
        end
        IDX_MON_CTRL: begin
          next_st.rdat[MON_ON_BIT] = st.monOn;
          next_st.rdat[MON_TEST_BIT] = st.monTest;
          next_st.rdat[MON_SRC_LSB +: 2] = st.monSrc;
        end
        IDX_IRQ_CTRL: begin
          next_st.rdat[IRQ_EN_BIT] = st.irqEn;
          next_st.rdat[IRQ_KIND_BIT] = st.irqKind;
        end
        IDX_IRQ_FLAGS: next_st.rdat[FLAG_FAIL_BIT] = st.failFlag;
        IDX_STATUS: next_st.rdat[STAT_PLL_BIT] = pllRunning;
        default: next_st.rdat = '0;
      endcase
    end
    if (wrLane) begin
      case (idx)
        IDX_GUARD: begin
          if (wbyte == GUARD_KEY) begin
            next_st.guard = GUARD_WINDOW;
          end
        end
        IDX_SELECT: begin
          if (unlocked) begin
            next_st.clkOutOn = wbyte[SEL_CLOCK_OUT_ENABLE_BIT];
            next_st.srcSel = wbyte[SEL_SRC_LSB +: 4];
            next_st.guard = 3'h0;
          end
        end
        IDX_PRESCALE: begin
          if (unlocked) begin
            next_st.preOn = wbyte[PRE_ON_BIT];
            next_st.ratio = wbyte[PRE_RATIO_LSB +: 4];
            next_st.guard = 3'h0;
          end
        end
        IDX_MON_CTRL: begin
          if (unlocked) begin
            next_st.monTest = wbyte[MON_TEST_BIT];
            if (!locked) begin
              next_st.monOn = wbyte[MON_ON_BIT];
              next_st.monSrc = wbyte[MON_SRC_LSB +: 2];
            end
            next_st.guard = 3'h0;
          end
        end
        IDX_IRQ_CTRL: begin
          if (unlocked) begin
            if (!locked) begin
              next_st.irqEn = wbyte[IRQ_EN_BIT];
              next_st.irqKind = wbyte[IRQ_KIND_BIT];
            end
            next_st.guard = 3'h0;
          end
        end
        IDX_IRQ_FLAGS: begin
          if (wbyte[FLAG_FAIL_BIT]) begin
            next_st.failFlag = 1'b0;
          end
        end
        default: next_st.guard = next_st.guard;
      endcase
    end
    // hardware set wins over a simultaneous clear
    if (failure) begin
      next_st.failFlag = 1'b1;
    end
    if (failure && st.monSrc == MON_MAIN) begin
      next_st.clkOutOn = 1'b0;
      if (st.monTest) begin
        next_st.srcSel = SRC_STARTUP;
      end
    end
    // outputs all registered
    next_st.mainClk = pick_src(next_st.srcSel, oscClk);
    next_st.clock_out_enable = next_st.clkOutOn && next_st.mainClk;
    next_st.clkOutEn = next_st.clkOutOn;
    next_st.irq = next_st.failFlag && next_st.irqEn &&
                  !next_st.irqKind;
    next_st.nmi = next_st.failFlag && next_st.irqEn &&
                  next_st.irqKind;
  end

  always_ff @(posedge ref_clk or negedge nrst) begin
    if (!nrst) begin
      st <= '0;
    end else begin
      st <= next_st;
    end
  end

  logic prescaleTickQ;
  always_ff @(posedge ref_clk or negedge nrst) begin
    if (!nrst) begin
      prescaleTickQ <= 1'b0;
    end else begin
      prescaleTickQ <= tick;
    end
  end

  assign wbRsp.ack = st.ack;
  assign wbRsp.dat = st.rdat;
  assign mainClock = st.mainClk;
  assign clockOut = st.clock_out_enable;
  assign clockOutEn = st.clkOutEn;
  assign mainSource = st.srcSel;
  assign prescaleTick = prescaleTickQ;
  assign failIrq = st.irq;
  assign failNmi = st.nmi;

  a_lock_holds: assert property (@(posedge ref_clk) disable iff (!nrst)
    locked |=> (st.monOn && st.irqEn && st.irqKind && st.monSrc ==
    $past(st.monSrc))) else $error("locked bits changed");
  a_flag_sets: assert property (@(posedge ref_clk) disable iff (!nrst)
    failure |=> st.failFlag) else $error("flag not set");
  a_flag_clear: assert property (@(posedge ref_clk) disable iff (!nrst)
    (wrLane && idx == IDX_IRQ_FLAGS && wbyte[FLAG_FAIL_BIT] && !failure)
    |=> !st.failFlag) else $error("flag not cleared");
  a_idle_mon: assert property (@(posedge ref_clk) disable iff (!nrst)
    !st.monOn |-> !failure) else $error("monitor active");
  a_clock_out_enable_off: assert property (@(posedge ref_clk) disable iff (!nrst)
    (failure && st.monSrc == MON_MAIN) |=> !clockOutEn)
    else $error("clock out kept");
  a_startup_sw: assert property (@(posedge ref_clk) disable iff (!nrst)
    (failure && st.monTest && st.monSrc == MON_MAIN) |=>
    st.srcSel == SRC_STARTUP) else $error("no start-up switch");
  a_irq_gate: assert property (@(posedge ref_clk) disable iff (!nrst)
    (failIrq || failNmi) |-> st.irqEn)
    else $error("request while disabled");
  a_irq_kind: assert property (@(posedge ref_clk) disable iff (!nrst)
    !(failIrq && failNmi)) else $error("both request kinds");
  a_guarded_wr: assert property (@(posedge ref_clk) disable iff (!nrst)
    (wrLane && idx == IDX_PRESCALE && !unlocked) |=>
    $stable(st.ratio)) else $error("unguarded write");
  a_pll_read: assert property (@(posedge ref_clk) disable iff (!nrst)
    (access && !wbReq.we && idx == IDX_STATUS) |=>
    wbRsp.dat[STAT_PLL_BIT] == $past(pllRunning))
    else $error("pll status wrong");

  // register fields other than the failure flag and the guard move only through guarded writes or a failure
  a_clock_out_enable_gate: assert property (@(posedge ref_clk) disable iff (!nrst)
    clockOut |-> clockOutEn) else $error("clock out while off");
  a_clock_out_enable_copy: assert property (@(posedge ref_clk) disable iff (!nrst)
    clockOutEn |-> clockOut == mainClock) else $error("clock out");
  a_clock_out_enable_wr: assert property (@(posedge ref_clk) disable iff (!nrst)
    (wrLane && idx == IDX_SELECT && unlocked && !failure) |=>
    st.clkOutOn == $past(wbyte[SEL_CLOCK_OUT_ENABLE_BIT])) else $error("enable");
  a_src_write: assert property (@(posedge ref_clk) disable iff (!nrst)
    (wrLane && idx == IDX_SELECT && unlocked && !failure) |=>
    st.srcSel == $past(wbyte[SEL_SRC_LSB +: 4])) else $error("source");
  a_src_hold: assert property (@(posedge ref_clk) disable iff (!nrst)
    (!access && !failure) |=> $stable(st.srcSel))
    else $error("source moved");
  a_pick_slow: assert property (@(posedge ref_clk) disable iff (!nrst)
    (mainSource == SRC_INT_SLOW) |-> mainClock == $past(oscClk.intSlow))
    else $error("slow source");
  a_pick_watch: assert property (@(posedge ref_clk) disable iff (!nrst)
    (mainSource == SRC_EXT_WATCH) |-> mainClock == $past(oscClk.extWatch))
    else $error("watch source");
  a_pick_fast: assert property (@(posedge ref_clk) disable iff (!nrst)
    (mainSource == SRC_EXT_FAST) |-> mainClock == $past(oscClk.extFast))
    else $error("fast source");
  a_ratio_wr: assert property (@(posedge ref_clk) disable iff (!nrst)
    (wrLane && idx == IDX_PRESCALE && unlocked) |=>
    st.ratio == $past(wbyte[PRE_RATIO_LSB +: 4])) else $error("ratio");
  a_ratio_hold: assert property (@(posedge ref_clk) disable iff (!nrst)
    !wrLane |=> $stable(st.ratio)) else $error("ratio moved");
  a_pre_off: assert property (@(posedge ref_clk) disable iff (!nrst)
    !st.preOn |=> tick) else $error("undivided tick missing");
  a_mon_src_wr: assert property (@(posedge ref_clk) disable iff (!nrst)
    (wrLane && idx == IDX_MON_CTRL && unlocked && !locked) |=>
    st.monSrc == $past(wbyte[MON_SRC_LSB +: 2])) else $error("msrc");
  a_lock_sticky: assert property (@(posedge ref_clk) disable iff (!nrst)
    locked |=> locked) else $error("lock released");
  a_test_wr: assert property (@(posedge ref_clk) disable iff (!nrst)
    (wrLane && idx == IDX_MON_CTRL && unlocked) |=>
    st.monTest == $past(wbyte[MON_TEST_BIT])) else $error("test bit");
  a_test_fail: assert property (@(posedge ref_clk) disable iff (!nrst)
    (st.monOn && st.monTest) |-> failure) else $error("no forced");
  a_irq_level: assert property (@(posedge ref_clk) disable iff (!nrst)
    failIrq |-> (st.failFlag && st.irqEn && !st.irqKind))
    else $error("regular request wrong");
  a_nmi_level: assert property (@(posedge ref_clk) disable iff (!nrst)
    failNmi |-> (st.failFlag && st.irqEn && st.irqKind))
    else $error("non-maskable request wrong");
  a_flag_spur: assert property (@(posedge ref_clk) disable iff (!nrst)
    (!st.failFlag && !failure) |=> !st.failFlag)
    else $error("flag set without failure");
  a_flag_hold: assert property (@(posedge ref_clk) disable iff (!nrst)
    (st.failFlag && !(wrLane && idx == IDX_IRQ_FLAGS &&
    wbyte[FLAG_FAIL_BIT])) |=> st.failFlag) else $error("flag lost");
  a_ack_pulse: assert property (@(posedge ref_clk) disable iff (!nrst)
    wbRsp.ack |=> !wbRsp.ack) else $error("ack held");
  a_unguarded_sel: assert property (@(posedge ref_clk) disable iff (!nrst)
    (wrLane && idx == IDX_SELECT && !unlocked && !failure) |=>
    $stable(st.srcSel)) else $error("unguarded select");
  a_reserved_mon: assert property (@(posedge ref_clk) disable iff (!nrst)
    (!st.monTest && st.monSrc > MON_EXT_WATCH) |-> !failure)
    else $error("reserved source failed");
endmodule : mcs_main_clock_ctrl

// >>> testbench/testbench.sv
`timescale 1ns/1ns
module testbench
  import mcs_pkg::*;
;
  typedef struct {logic [2:0] idx; logic [7:0] d;} mcs_row_t;
  logic ref_clk = 1'b0;
  logic nrst = 1'b0;
  mcs_wb_req_t wbReq = '0;
  mcs_wb_rsp_t wbRsp;
  mcs_osc_t oscClk = '0;
  mcs_osc_t oscLost = '0;
  logic pllRunning = 1'b0;
  logic mainClock, clockOut, clockOutEn, prescaleTick, failIrq, failNmi;
  logic [3:0] mainSource;
  int nErrors = 0;
  int testsRun = 0;
  int n;
  logic [7:0] q;
  // every row is written through the guard and read back unchanged
  mcs_row_t rows [10] = '{'{3'h0, 8'h80}, '{3'h0, 8'h81}, '{3'h0, 8'h82},
    '{3'h0, 8'h83}, '{3'h1, 8'h19}, '{3'h1, 8'h0b}, '{3'h3, 8'h80},
    '{3'h3, 8'h00}, '{3'h2, 8'h08}, '{3'h2, 8'h00}};

  mcs_main_clock_ctrl mcs_main_clock_ctrl_inst (
    .ref_clk(ref_clk), .nrst(nrst), .wbReq(wbReq), .wbRsp(wbRsp),
    .oscClk(oscClk), .oscLost(oscLost), .pllRunning(pllRunning),
    .mainClock(mainClock), .clockOut(clockOut), .clockOutEn(clockOutEn),
    .mainSource(mainSource), .prescaleTick(prescaleTick),
    .failIrq(failIrq), .failNmi(failNmi));

  always #25 ref_clk = ~ref_clk;
  // oscillators toggle every cycle so the selected clock is visible
  always @(posedge ref_clk) oscClk <= ~oscClk;

  task automatic completeRun;
    $display("checks %0d errors %0d", testsRun, nErrors);
    if (nErrors == 0 && testsRun > 0) $display("Result: passed");
    else $display("Result: failed");
    $finish;
  endtask : completeRun

  task automatic chk(input string nm, input logic [7:0] e, g);
    testsRun++;
    if (g !== e) begin
      $display("MISMATCH %s expected %h seen %h", nm, e, g);
      nErrors++;
    end
  endtask : chk

  // entered just after a rising edge; ack is read before that edge's updates
  task automatic wb(input logic we, input logic [2:0] idx,
                    input logic [7:0] d, output logic [7:0] r);
    int i;
    i = 0;
    wbReq <= '{1'b1, 1'b1, we, {idx, 2'b00}, 4'h1, {24'h0, d}};
    do begin
      @(posedge ref_clk);
      i++;
    end while (wbRsp.ack !== 1'b1 && i < 20);
    r = wbRsp.dat[7:0];
    wbReq <= '0;
    if (i >= 20) begin
      nErrors++;
      completeRun();
    end
    @(posedge ref_clk);
  endtask : wb

  task automatic pw(input logic [2:0] idx, input logic [7:0] d);
    logic [7:0] r;
    wb(1'b1, IDX_GUARD, GUARD_KEY, r);
    wb(1'b1, idx, d, r);
  endtask : pw

  task automatic rd(input logic [2:0] idx, input logic [7:0] e);
    logic [7:0] r;
    wb(1'b0, idx, 8'h00, r);
    chk($sformatf("reg%0d", idx), e, r);
  endtask : rd

  task automatic ticks(input logic [7:0] code, input int cyc, input int e);
    int t;
    t = 0;
    pw(IDX_PRESCALE, code);
    repeat (8) @(posedge ref_clk);
    repeat (cyc) begin
      @(posedge ref_clk);
      t += prescaleTick;
    end
    chk("ticks", e[7:0], t[7:0]);
  endtask : ticks

  initial begin
    repeat (2) @(posedge ref_clk);
    nrst <= 1'b1;
    @(posedge ref_clk);
    for (int i = 0; i < 8; i++) rd(i[2:0], 8'h00);
    wb(1'b1, IDX_SELECT, 8'h83, q);
    rd(IDX_SELECT, 8'h00);
    foreach (rows[i]) begin
      pw(rows[i].idx, rows[i].d);
      rd(rows[i].idx, rows[i].d);
      if (rows[i].idx == IDX_SELECT) chk("src", rows[i].d[3:0], mainSource);
    end
    ticks(8'h03, 40, 10);
    ticks(8'h11, 48, 8);
    ticks(8'h00, 8, 8);
    n = 0;
    repeat (8) begin
      @(posedge ref_clk);
      n += clockOut;
    end
    chk("clock_out_enable on", 8'h01, {7'h0, n > 0 && n < 8});
    pllRunning <= 1'b1;
    rd(IDX_STATUS, 8'h20);
    pw(IDX_MON_CTRL, 8'h02);
    repeat (4) @(posedge ref_clk);
    rd(IDX_IRQ_FLAGS, 8'h00);
    pw(IDX_IRQ_CTRL, 8'h01);
    pw(IDX_MON_CTRL, 8'h03);
    repeat (4) @(posedge ref_clk);
    rd(IDX_IRQ_FLAGS, 8'h01);
    chk("irq", 8'h01, {7'h0, failIrq});
    chk("nmi", 8'h00, {7'h0, failNmi});
    chk("clock_out_enable en", 8'h00, {7'h0, clockOutEn});
    rd(IDX_SELECT, 8'h00);
    chk("src", {4'h0, SRC_STARTUP}, {4'h0, mainSource});
    n = 0;
    repeat (8) begin
      @(posedge ref_clk);
      n += clockOut;
    end
    chk("clock_out_enable off", 8'h00, n[7:0]);
    wb(1'b1, IDX_IRQ_FLAGS, 8'h00, q);
    rd(IDX_IRQ_FLAGS, 8'h01);
    pw(IDX_MON_CTRL, 8'h01);
    wb(1'b1, IDX_IRQ_FLAGS, 8'h01, q);
    rd(IDX_IRQ_FLAGS, 8'h00);
    chk("irq", 8'h00, {7'h0, failIrq});
    pw(IDX_IRQ_CTRL, 8'h00);
    pw(IDX_MON_CTRL, 8'h03);
    repeat (4) @(posedge ref_clk);
    chk("irq off", 8'h00, {7'h0, failIrq});
    pw(IDX_MON_CTRL, 8'h00);
    wb(1'b1, IDX_IRQ_FLAGS, 8'h01, q);
    pw(IDX_IRQ_CTRL, 8'h81);
    pw(IDX_MON_CTRL, 8'h01);
    pw(IDX_MON_CTRL, 8'h0a);
    rd(IDX_MON_CTRL, 8'h03);
    pw(IDX_IRQ_CTRL, 8'h00);
    rd(IDX_IRQ_CTRL, 8'h81);
    chk("nmi", 8'h01, {7'h0, failNmi});
    chk("irq", 8'h00, {7'h0, failIrq});
    nrst <= 1'b0;
    repeat (2) @(posedge ref_clk);
    nrst <= 1'b1;
    @(posedge ref_clk);
    pw(IDX_MON_CTRL, 8'h08);
    rd(IDX_MON_CTRL, 8'h08);
    rd(IDX_IRQ_CTRL, 8'h00);
    completeRun();
  end
endmodule : testbench
